//--- core/slbm_cfg.svh
// Purpose: Timing constants for the single line bus master
// Assumes: 250 MHz mclk, intervals in microseconds
// Notes: Cycle counts derive from the clock rate
`ifndef SLBM_CFG_SVH
`define SLBM_CFG_SVH
`define SLBM_CLK_MHZ 250
`define SLBM_TICK_CYC (`SLBM_CLK_MHZ)
`define SLBM_RST_LOW_US 511
`define SLBM_RST_HIGH_US 512
`define SLBM_RST_LIMIT_US 960
`define SLBM_W0_LOW_US 100
`define SLBM_SLOT_US 117
`define SLBM_REC_US 1
`define SLBM_W1_LOW_US 5
`define SLBM_RD_LOW_US 5
`define SLBM_RD_SAMPLE_US 15
`define SLBM_PD_MIN_US 15
`define SLBM_PD_MAX_US 60
`define SLBM_FIFO_DEPTH 16
`endif

//--- core/slbm_pkg.sv
// Purpose: Types for the single line bus master
// Assumes: Nothing beyond the header
// Notes: Commands enter through the FIFO
package slbm_pkg;
  typedef enum logic [1:0] {
    SLBM_CMD_RESET,
    SLBM_CMD_WRITE0,
    SLBM_CMD_WRITE1,
    SLBM_CMD_READ
  } slbm_cmd_t;
endpackage : slbm_pkg

//--- core/slbm_fifo.sv
// Purpose: Command FIFO with valid and ready on both sides
// Assumes: Single clock, asynchronous active high reset
// Notes: Read data come from a register
`timescale 1ns/1ps
module slbm_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire load = (count != '0) && (!out_valid || pop);

  // Full counts the head register too, so DEPTH words in all
  wire [AW:0] held = count + {{AW{1'b0}}, out_valid};
  assign in_ready = (held != (AW + 1)'(DEPTH));

  // Storage array, written on push
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // Pointers, occupancy and output register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (load) begin
        out_data <= mem[rptr];
        rptr <= rptr + 1'b1;
        out_valid <= 1'b1;
      end else if (pop) begin
        out_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end
endmodule : slbm_fifo

//--- core/slbm_master.sv
// Purpose: Single line bus master timing reset, write and read slots
// Assumes: 250 MHz mclk, open-drain line with external pull-up
// Notes: Commands queue in a 16 entry FIFO
`timescale 1ns/1ps
`include "slbm_cfg.svh"
module slbm_master
  import slbm_pkg::*;
#(
  parameter int FIFO_DEPTH = `SLBM_FIFO_DEPTH,
  parameter int TICK_CYC = `SLBM_TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_code,
  output logic rd_valid,
  output logic rd_bit,
  output logic presence_valid,
  output logic presence,
  output logic busy,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe
);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam logic [9:0] RST_LOW = 10'(`SLBM_RST_LOW_US);
  localparam logic [9:0] RST_HIGH = 10'(`SLBM_RST_HIGH_US);
  localparam logic [9:0] W0_LOW = 10'(`SLBM_W0_LOW_US);
  localparam logic [9:0] W1_LOW = 10'(`SLBM_W1_LOW_US);
  localparam logic [9:0] RD_LOW = 10'(`SLBM_RD_LOW_US);
  localparam logic [9:0] SLOT = 10'(`SLBM_SLOT_US);
  localparam logic [9:0] REC = 10'(`SLBM_REC_US);
  localparam logic [9:0] RD_SMP = 10'(`SLBM_RD_SAMPLE_US);
  localparam logic [9:0] PD_MIN = 10'(`SLBM_PD_MIN_US);
  localparam logic [9:0] PD_END = 10'(`SLBM_PD_MAX_US + `SLBM_PD_MIN_US);

  typedef enum logic [1:0] {
    SLBM_IDLE,
    SLBM_LOW,
    SLBM_HIGH,
    SLBM_RECOV
  } slbm_state_t;

  slbm_state_t state;
  slbm_cmd_t cur;
  logic [7:0] tick_cnt;
  logic [9:0] us_cnt;
  logic line_s1;
  logic line_s2;
  logic q_valid;
  logic [1:0] q_data;

  // Engine takes the queue head whenever it is idle
  wire q_pop = (state == SLBM_IDLE) && q_valid;

  // Command queue in front of the slot engine
  slbm_fifo #(.WIDTH(2), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_code),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_data)
  );

  // Low time per command
  function automatic logic [9:0] low_len(input slbm_cmd_t c);
    unique case (c)
      SLBM_CMD_RESET: low_len = RST_LOW;
      SLBM_CMD_WRITE0: low_len = W0_LOW;
      SLBM_CMD_WRITE1: low_len = W1_LOW;
      SLBM_CMD_READ: low_len = RD_LOW;
    endcase
  endfunction : low_len

  // Phase decode
  wire tick = (tick_cnt == TICK_LAST);
  wire is_rst = (cur == SLBM_CMD_RESET);
  wire low_done = tick && (us_cnt == low_len(cur) - 10'd1);
  wire high_done = tick && (is_rst ? us_cnt == RST_HIGH - 10'd1
                                   : us_cnt == SLOT - 10'd1);
  wire rec_done = tick && (us_cnt == REC - 10'd1);
  wire rd_sample = tick && (cur == SLBM_CMD_READ) && (state == SLBM_HIGH)
                   && (us_cnt == RD_SMP - RD_LOW - 10'd1);
  wire pd_window = (state == SLBM_HIGH) && is_rst
                   && (us_cnt >= PD_MIN) && (us_cnt < PD_END);

  // Open drain: drive low only, never high
  assign line_out = 1'b0;
  assign line_oe = (state == SLBM_LOW);
  assign busy = (state != SLBM_IDLE) || q_valid;

  // Two-flop synchroniser on the line
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
    end else begin
      line_s1 <= line_in;
      line_s2 <= line_s1;
    end
  end

  // Microsecond tick prescaler, restarts with each phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt <= '0;
    end else if (state == SLBM_IDLE || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 8'd1;
    end
  end

  // Slot sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= SLBM_IDLE;
      cur <= SLBM_CMD_RESET;
      us_cnt <= '0;
    end else begin
      unique case (state)
        SLBM_IDLE: begin
          us_cnt <= '0;
          if (q_valid) begin
            cur <= slbm_cmd_t'(q_data);
            state <= SLBM_LOW;
          end
        end
        SLBM_LOW: begin
          if (low_done) begin
            us_cnt <= '0;
            state <= SLBM_HIGH;
          end else if (tick) begin
            us_cnt <= us_cnt + 10'd1;
          end
        end
        SLBM_HIGH: begin
          // Slot length counted from its falling edge
          if (is_rst ? high_done
                     : tick && us_cnt + low_len(cur) == SLOT - 10'd1) begin
            us_cnt <= '0;
            state <= SLBM_RECOV;
          end else if (tick) begin
            us_cnt <= us_cnt + 10'd1;
          end
        end
        SLBM_RECOV: begin
          if (rec_done) begin
            state <= SLBM_IDLE;
          end else if (tick) begin
            us_cnt <= us_cnt + 10'd1;
          end
        end
      endcase
    end
  end

  // Read data and presence results
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_bit <= 1'b0;
      presence <= 1'b0;
      presence_valid <= 1'b0;
    end else begin
      rd_valid <= rd_sample;
      if (rd_sample) begin
        rd_bit <= line_s2;
      end
      if (q_pop && q_data == 2'(SLBM_CMD_RESET)) begin
        presence <= 1'b0;
      end else if (pd_window && !line_s2) begin
        presence <= 1'b1;
      end
      presence_valid <= is_rst && (state == SLBM_RECOV) && rec_done;
    end
  end

  // Low-phase length in cycles for checking
  logic [19:0] low_cyc;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_cyc <= '0;
    end else if (line_oe) begin
      low_cyc <= low_cyc + 20'd1;
    end else begin
      low_cyc <= '0;
    end
  end

  property p_rst_low;
    @(posedge mclk) disable iff (rst)
    $fell(line_oe) && is_rst
      |-> $past(low_cyc) == 20'(`SLBM_RST_LOW_US * TICK_CYC - 1);
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("reset low time wrong");
  property p_rst_limit;
    @(posedge mclk) disable iff (rst)
    line_oe |-> low_cyc < 20'(`SLBM_RST_LIMIT_US * TICK_CYC);
  endproperty
  a_rst_limit: assert property (p_rst_limit)
    else $error("low pulse too long");
  property p_w0_low;
    @(posedge mclk) disable iff (rst)
    $fell(line_oe) && cur == SLBM_CMD_WRITE0
      |-> $past(low_cyc) == 20'(`SLBM_W0_LOW_US * TICK_CYC - 1);
  endproperty
  a_w0_low: assert property (p_w0_low)
    else $error("write zero low time wrong");
  property p_short_low;
    @(posedge mclk) disable iff (rst)
    $fell(line_oe) && (cur == SLBM_CMD_WRITE1 || cur == SLBM_CMD_READ)
      |-> $past(low_cyc) == 20'(`SLBM_W1_LOW_US * TICK_CYC - 1);
  endproperty
  a_short_low: assert property (p_short_low)
    else $error("short low time wrong");
  property p_recov;
    @(posedge mclk) disable iff (rst)
    $rose(state == SLBM_RECOV) |-> !line_oe [*8];
  endproperty
  a_recov: assert property (p_recov)
    else $error("recovery violated");
  property p_slot_end;
    @(posedge mclk) disable iff (rst)
    $rose(state == SLBM_RECOV) && !is_rst |-> $past(us_cnt) + low_len(cur)
      == SLOT - 10'd1;
  endproperty
  a_slot_end: assert property (p_slot_end)
    else $error("slot length wrong");
  property p_rst_high;
    @(posedge mclk) disable iff (rst)
    $rose(state == SLBM_RECOV) && is_rst
      |-> $past(us_cnt) == 10'(`SLBM_RST_HIGH_US - 1);
  endproperty
  a_rst_high: assert property (p_rst_high)
    else $error("reset high time wrong");
  property p_sample;
    @(posedge mclk) disable iff (rst)
    rd_valid |-> $past(state) == SLBM_HIGH
      && $past(us_cnt) == 10'(`SLBM_RD_SAMPLE_US - `SLBM_RD_LOW_US - 1);
  endproperty
  a_sample: assert property (p_sample)
    else $error("read sample point wrong");
  property p_drive;
    @(posedge mclk) disable iff (rst) line_oe |-> line_out == 1'b0;
  endproperty
  a_drive: assert property (p_drive)
    else $error("line driven high");

  c_reset: cover property (@(posedge mclk) presence_valid && presence);
  c_read: cover property (@(posedge mclk) rd_valid);
  c_w0: cover property (@(posedge mclk) $fell(line_oe)
                        && cur == SLBM_CMD_WRITE0);
  c_full: cover property (@(posedge mclk) !cmd_ready);
endmodule : slbm_master

//--- verif/slbm_slave_model.sv
// Purpose: Slave device model on the shared line
// Assumes: Line has a pull-up; delays in ns
// Notes: Answers each slot from a bit pattern
`timescale 1ns/1ps
module slbm_slave_model #(
  parameter real US_NS = 1000.0
) (
  input wire logic rst,
  input wire logic line,
  input wire logic present,
  input wire logic slow,
  input wire logic [31:0] bits,
  output logic pull
);
  int idx = 0;
  realtime t0;
  initial pull = 1'b0;
  // Slot answer, then presence after a long low
  always @(negedge line) begin
    if (!pull && !rst) begin
      t0 = $realtime;
      if (!bits[idx[4:0]]) begin
        #(2 * US_NS) pull = 1'b1;
        #(28 * US_NS) pull = 1'b0;
      end
      idx++;
      wait (line === 1'b1);
      if (present && $realtime - t0 >= 480 * US_NS) begin
        #((slow ? 60 : 15) * US_NS) pull = 1'b1;
        #((slow ? 240 : 60) * US_NS) pull = 1'b0;
      end
    end
  end
endmodule : slbm_slave_model

//--- verif/test_slbm_master.sv
// Purpose: Self-checking bench for the line master
// Assumes: 250 MHz clock, one slave model
// Notes: Pulse widths are measured on line_oe
`timescale 1ns/1ps
module test_slbm_master;
  import slbm_pkg::*;
  // Cycles per microsecond; a short tick keeps the run brief
  localparam int US = 20;
  localparam int DEPTH = 4;
  logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic cmd_ready, rd_valid, rd_bit, presence_valid, presence, busy;
  logic line_out, line_oe, pull, ok, ebit;
  logic present = 1'b1, slow = 1'b0, was_oe = 1'b0, fresh = 1'b1;
  logic [1:0] cur, c;
  logic [31:0] bits = 32'h0;
  logic [1:0] q[$];
  int cyc = 0, t_rise = 0, t_fall = 0, nrise = 0, n;
  int bad_count = 0, n_tests = 0, d = 0;
  wire line = !((line_oe && !line_out) || pull);
  always #2 mclk = ~mclk;
  slbm_master #(.FIFO_DEPTH(DEPTH), .TICK_CYC(US)) u_slbm_master (
    .mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .rd_valid(rd_valid), .rd_bit(rd_bit), .presence_valid(presence_valid),
    .presence(presence), .busy(busy), .line_in(line),
    .line_out(line_out), .line_oe(line_oe));
  slbm_slave_model #(.US_NS(US * 4.0)) u_slbm_slave_model (.rst(rst),
    .line(line), .present(present), .slow(slow), .bits(bits), .pull(pull));
  // Shortest and longest low time per command, in us
  function automatic int lo_us(logic [1:0] k);
    case (k) 2'h0: return 480; 2'h1: return 60; default: return 1; endcase
  endfunction : lo_us
  function automatic int hi_us(logic [1:0] k);
    case (k) 2'h0: return 959; 2'h1: return 120; default: return 15; endcase
  endfunction : hi_us
  task automatic check_range(input int v, input int lo, input int hi);
    n_tests++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h..%h", $time, v, lo, hi);
    end
  endtask : check_range
  task automatic check_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : check_bit
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  // Offer one command; ok tells whether it was taken
  task automatic push(input logic [1:0] k, output logic r);
    cmd_valid <= 1'b1;
    cmd_code <= k;
    @(negedge mclk);
    r = cmd_ready;
    if (r) q.push_back(k);
    @(posedge mclk);
  endtask : push
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (busy !== 1'b0 && k < 40000);
    if (k >= 40000) begin
      bad_count++;
      end_of_test();
    end
    fresh = 1'b1;
    repeat (100) @(posedge mclk);
  endtask : wait_idle
  // Pulse, gap and answer timing seen at settled values
  always @(negedge mclk) begin
    cyc <= cyc + 1;
    if (line_oe && !was_oe) begin
      if (fresh) begin
      end else if (cur == 2'h0) begin
        check_range(cyc - t_fall, 480 * US, 1000 * US);
      end else begin
        check_range(cyc - t_rise, 61 * US, 122 * US);
      end
      fresh <= 1'b0;
      t_rise <= cyc;
      cur <= q.pop_front();
      ebit <= bits[nrise[4:0]];
      nrise <= nrise + 1;
      check_bit(line_out, 1'b0);
    end
    if (!line_oe && was_oe) begin
      t_fall <= cyc;
      d = cyc - t_rise;
      check_range(d, lo_us(cur) * US, hi_us(cur) * US);
    end
    if (rd_valid) begin
      check_bit(rd_bit, ebit);
      check_range(cyc - t_rise, 14 * US, 16 * US);
    end
    if (presence_valid) begin
      check_bit(presence, present);
      check_range(cyc - t_fall, 480 * US, 1000 * US);
    end
    was_oe <= line_oe;
  end
  // Reset with presence, FIFO fill, reset with no slave
  initial begin
    bits = $urandom(72);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int t = 0; t < 3; t++) begin
      present <= (t == 0);
      slow <= 1'($urandom);
      n = 0;
      if (t == 1) begin
        ok = 1'b1;
        while (ok && n < 20) begin
          c = (n < 3) ? 2'(n + 1) : 2'($urandom_range(3, 1));
          push(c, ok);
          n++;
        end
        // Queue holds DEPTH words and the engine one more
        check_range(n - 1, DEPTH + 1, DEPTH + 1);
      end else begin
        push(2'h0, ok);
        push(2'h3, ok);
      end
      cmd_valid <= 1'b0;
      wait_idle();
      $display("test %0d done", t);
    end
    end_of_test();
  end
endmodule : test_slbm_master
